// ---- common/sbim_pkg.sv ----
package sbim_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] SBIM_PRIO_OFS = 8'h0C;
  localparam logic [7:0] SBIM_STAT_OFS = 8'h10;
  localparam logic [7:0] SBIM_PEND_OFS = 8'h14;
  localparam logic [7:0] SBIM_PTR_OFS = 8'h18;
  localparam logic [7:0] SBIM_TXMAP_OFS = 8'h1C;
  localparam logic [7:0] SBIM_RXSZ1_OFS = 8'h20;
  localparam logic [7:0] SBIM_RXOF1_OFS = 8'h24;
  localparam logic [7:0] SBIM_RXSZ2_OFS = 8'h28;
  localparam logic [7:0] SBIM_RXOF2_OFS = 8'h2C;
  localparam logic [7:0] SBIM_RXSZ3_OFS = 8'h30;
  localparam logic [7:0] SBIM_RXOF3_OFS = 8'h34;
  localparam logic [7:0] SBIM_RXSZ4_OFS = 8'h38;
  localparam logic [7:0] SBIM_RXOF4_OFS = 8'h3C;
  localparam logic [7:0] SBIM_CTRL_OFS = 8'h40;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int SBIM_CTRL_LOCAL_BIT = 0;
  localparam int SBIM_CTRL_CFG_BIT = 1;
  localparam logic [31:0] SBIM_RESET_VAL = 32'h0000_0000;
  localparam logic [31:0] SBIM_WORD_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] SBIM_CTRL_MASK = 32'h0000_0003;
  localparam logic [25:0] SBIM_TX_ADDR_MASK = 26'h3FF_FFFF;
  localparam int SBIM_NOPEND_BIT = 31;
  localparam int SBIM_REGIONS = 4;

  // bus write from software
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
  } sbim_wr_s;

  // interrupt packet sender state
  typedef enum logic [0:0] {
    SBIM_IDLE = 1'b0,
    SBIM_SEND = 1'b1
  } sbim_pkt_e;

endpackage

// ---- logic/sbim_rx_map.sv ----
`timescale 1ns/10ps
// receive address translation over the mapped regions
module sbim_rx_map #(
  parameter int REGIONS = 4
) (
  input wire logic [31:0] i_addr,
  input wire logic [REGIONS*32-1:0] i_size,
  input wire logic [REGIONS*32-1:0] i_offset,
  output logic [31:0] o_addr,
  output logic o_hit
);
  import sbim_pkg::*;

  logic [REGIONS-1:0] below;
  logic [REGIONS*32-1:0] trans;

  // per region compare and add
  genvar g;
  generate
    for (g = 0; g < REGIONS; g++) begin : g_reg
      assign below[g] = i_addr < i_size[g*32 +: 32];
      assign trans[g*32 +: 32] = i_addr + i_offset[g*32 +: 32];
    end
  endgenerate

  // lowest numbered region wins
  always_comb begin
    o_addr = i_addr;
    o_hit = 1'b0;
    for (int k = REGIONS - 1; k >= 0; k--) begin
      if (below[k]) begin
        o_addr = trans[k*32 +: 32];
        o_hit = 1'b1;
      end
    end
  end

endmodule // sbim_rx_map

// ---- logic/sbim_top.sv ----
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
// What this block does
// - status register shows unmasked state of each of 32 sources
// - writing one to a set status bit clears it
// - interrupt output high when any status bit set and local mode on
// - with local mode off, pending register holds bits awaiting forwarding
// - pending bits sent in a packet are then cleared
// - writing zero to a pending bit does nothing
// - writing one to pending, local mode off, sends an interrupt packet
// - writing one to pending, local mode on, raises interrupt output
// - outbound address is bus address [25:0] minus the rebase field
// - inbound address below region size gets region offset added
// - four size and offset region pairs, first picked by size one
// - priority vector reports lowest set status bit; writing it clears it
module sbim_top (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [31:0] i_irq_src,
  output logic o_module_interrupt_out,
  output logic o_pkt_valid,
  output logic [31:0] o_pkt_bits,
  input wire logic i_pkt_ready,
  input wire logic [31:0] i_tx_bus_addr,
  output logic [25:0] o_tx_pkt_addr,
  input wire logic [31:0] i_rx_pkt_addr,
  output logic [31:0] o_rx_local_addr,
  output logic o_rx_hit,
  output logic o_local_mode,
  output logic o_int_to_cfg
);
  import sbim_pkg::*;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  sbim_wr_s wr;
  logic [31:0] status_reg;
  logic [31:0] pending_reg;
  logic [31:0] ptr_reg;
  logic [31:0] txmap_reg;
  logic [31:0] ctrl_reg;
  logic [SBIM_REGIONS*32-1:0] size_reg;
  logic [SBIM_REGIONS*32-1:0] ofs_reg;
  sbim_pkt_e pkt_reg;
  logic local_mode;
  logic [4:0] prio_vec;
  logic any_status;
  logic [31:0] stat_clr;
  logic [31:0] pend_set;
  logic [31:0] pkt_clr;
  logic [31:0] rdata_next;
  logic [31:0] rx_addr;
  logic rx_hit;

  assign wr = '{addr: i_addr, data: i_wdata};
  assign local_mode = ctrl_reg[SBIM_CTRL_LOCAL_BIT];
  assign any_status = |status_reg;

  // ----------------------------------------
  // interrupt status and priority vector
  // ----------------------------------------

  // lowest numbered status bit is highest priority
  always_comb begin
    prio_vec = 5'h00;
    for (int k = 31; k >= 0; k--) begin
      if (status_reg[k]) begin
        prio_vec = k[4:0];
      end
    end
  end

  // clear mask from status or priority writes
  always_comb begin
    stat_clr = 32'h0000_0000;
    if (i_wr && wr.addr == SBIM_STAT_OFS) begin
      stat_clr = wr.data;
    end else if (i_wr && wr.addr == SBIM_PRIO_OFS) begin
      stat_clr[wr.data[4:0]] = 1'b1;
    end
  end

  // pending write sets, local-mode writes land in status
  assign pend_set = (i_wr && wr.addr == SBIM_PEND_OFS) ? wr.data
                                                        : 32'h0000_0000;

  // status: sources and local sets win over clears
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_reg <= SBIM_RESET_VAL;
    end else begin
      status_reg <= (status_reg & ~stat_clr) | i_irq_src
                    | (local_mode ? pend_set : 32'h0000_0000);
    end
  end

  // module interrupt output
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_module_interrupt_out <= 1'b0;
    end else begin
      o_module_interrupt_out <= (|((status_reg & ~stat_clr) | i_irq_src
                                | pend_set)) && local_mode;
    end
  end

  // ----------------------------------------
  // pending register and packet sender
  // ----------------------------------------

  // bits handed to the link this cycle are cleared
  assign pkt_clr = (pkt_reg == SBIM_SEND && i_pkt_ready) ? o_pkt_bits
                                                          : 32'h0000_0000;

  // pending: ones set, zeros ignored, sent bits cleared, set wins
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pending_reg <= SBIM_RESET_VAL;
    end else if (!local_mode) begin
      pending_reg <= (pending_reg & ~pkt_clr) | pend_set;
    end
  end

  // packet offered while pending bits wait in forwarding mode
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pkt_reg <= SBIM_IDLE;
      o_pkt_valid <= 1'b0;
      o_pkt_bits <= SBIM_RESET_VAL;
    end else begin
      case (pkt_reg)
        SBIM_IDLE: begin
          if (!local_mode && |pending_reg) begin
            pkt_reg <= SBIM_SEND;
            o_pkt_valid <= 1'b1;
            o_pkt_bits <= pending_reg;
          end
        end
        SBIM_SEND: begin
          if (i_pkt_ready) begin
            pkt_reg <= SBIM_IDLE;
            o_pkt_valid <= 1'b0;
          end
        end
        default: begin
          pkt_reg <= SBIM_IDLE;
          o_pkt_valid <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------

  // pointer, rebase and control
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ptr_reg <= SBIM_RESET_VAL;
      txmap_reg <= SBIM_RESET_VAL;
      ctrl_reg <= SBIM_RESET_VAL;
    end else if (i_wr) begin
      if (wr.addr == SBIM_PTR_OFS) begin
        ptr_reg <= wr.data & SBIM_WORD_MASK;
      end else if (wr.addr == SBIM_TXMAP_OFS) begin
        txmap_reg <= wr.data & SBIM_WORD_MASK;
      end else if (wr.addr == SBIM_CTRL_OFS) begin
        ctrl_reg <= wr.data & SBIM_CTRL_MASK;
      end
    end
  end

  // region size and offset pairs
  genvar g;
  generate
    for (g = 0; g < SBIM_REGIONS; g++) begin : g_rgn
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          size_reg[g*32 +: 32] <= SBIM_RESET_VAL;
          ofs_reg[g*32 +: 32] <= SBIM_RESET_VAL;
        end else if (i_wr) begin
          if (wr.addr == SBIM_RXSZ1_OFS + 8'(g * 8)) begin
            size_reg[g*32 +: 32] <= wr.data & SBIM_WORD_MASK;
          end else if (wr.addr == SBIM_RXOF1_OFS + 8'(g * 8)) begin
            ofs_reg[g*32 +: 32] <= wr.data & SBIM_WORD_MASK;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // address translation
  // ----------------------------------------
  sbim_rx_map #(
    .REGIONS(SBIM_REGIONS)
  ) u_rx_map (
    .i_addr(i_rx_pkt_addr),
    .i_size(size_reg),
    .i_offset(ofs_reg),
    .o_addr(rx_addr),
    .o_hit(rx_hit)
  );

  // registered translations
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx_pkt_addr <= 26'h000_0000;
      o_rx_local_addr <= SBIM_RESET_VAL;
      o_rx_hit <= 1'b0;
      o_local_mode <= 1'b0;
      o_int_to_cfg <= 1'b0;
    end else begin
      o_tx_pkt_addr <= (i_tx_bus_addr[25:0] - txmap_reg[25:0])
                       & SBIM_TX_ADDR_MASK;
      o_rx_local_addr <= rx_addr;
      o_rx_hit <= rx_hit;
      o_local_mode <= local_mode;
      o_int_to_cfg <= ctrl_reg[SBIM_CTRL_CFG_BIT];
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (wr.addr == SBIM_PRIO_OFS) begin
      rdata_next = {~any_status, 26'h000_0000, prio_vec};
    end else if (wr.addr == SBIM_STAT_OFS) begin
      rdata_next = status_reg;
    end else if (wr.addr == SBIM_PEND_OFS) begin
      rdata_next = pending_reg;
    end else if (wr.addr == SBIM_PTR_OFS) begin
      rdata_next = ptr_reg;
    end else if (wr.addr == SBIM_TXMAP_OFS) begin
      rdata_next = txmap_reg;
    end else if (wr.addr == SBIM_CTRL_OFS) begin
      rdata_next = ctrl_reg;
    end else begin
      for (int k = 0; k < SBIM_REGIONS; k++) begin
        if (wr.addr == SBIM_RXSZ1_OFS + 8'(k * 8)) begin
          rdata_next = size_reg[k*32 +: 32];
        end else if (wr.addr == SBIM_RXOF1_OFS + 8'(k * 8)) begin
          rdata_next = ofs_reg[k*32 +: 32];
        end
      end
    end
  end

  // read data valid one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= SBIM_RESET_VAL;
    end else begin
      o_rdata <= i_rd ? rdata_next : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  status_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_wr && i_addr == SBIM_STAT_OFS && i_irq_src == 32'h0000_0000
     && !local_mode) |=> ((status_reg & $past(i_wdata)) == 32'h0000_0000))
    else $error("status bit not cleared");
  status_keep_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (!(i_wr && (i_addr == SBIM_STAT_OFS || i_addr == SBIM_PRIO_OFS)))
    |=> ((status_reg & $past(status_reg)) == $past(status_reg)))
    else $error("status bit lost");
  source_seen_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    |i_irq_src |=> ((status_reg & $past(i_irq_src)) == $past(i_irq_src)))
    else $error("source not shown");
  irq_out_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ##1 (o_module_interrupt_out == ($past(local_mode) && |status_reg)))
    else $error("interrupt output wrong");
  local_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_wr && i_addr == SBIM_PEND_OFS && |i_wdata && local_mode)
    |=> o_module_interrupt_out)
    else $error("local set not raised");
  pend_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (pkt_reg == SBIM_IDLE || !i_pkt_ready) && !local_mode
    |=> ((pending_reg & $past(pending_reg)) == $past(pending_reg)))
    else $error("pending bit dropped");
  packet_go_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_wr && i_addr == SBIM_PEND_OFS && |i_wdata && !local_mode
     && pkt_reg == SBIM_IDLE && !ctrl_reg[SBIM_CTRL_LOCAL_BIT]
     && pending_reg == 32'h0000_0000)
    ##1 !local_mode |=> o_pkt_valid)
    else $error("packet not offered");
  packet_clr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_pkt_valid && i_pkt_ready && !local_mode
     && !(i_wr && i_addr == SBIM_PEND_OFS))
    |=> ((pending_reg & $past(o_pkt_bits)) == 32'h0000_0000))
    else $error("sent bits not cleared");
  tx_rebase_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ##1 (o_tx_pkt_addr == 26'($past(i_tx_bus_addr[25:0])
                              - $past(txmap_reg[25:0]))))
    else $error("tx address wrong");
  rx_first_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_rx_pkt_addr < size_reg[31:0]) |=>
    (o_rx_hit && o_rx_local_addr == $past(i_rx_pkt_addr)
                                    + $past(ofs_reg[31:0])))
    else $error("rx region one wrong");
  prio_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_rd && i_addr == SBIM_PRIO_OFS && status_reg[0])
    |=> (o_rdata[4:0] == 5'h00 && !o_rdata[SBIM_NOPEND_BIT]))
    else $error("priority vector wrong");

endmodule // sbim_top

// ---- testbench/sbim_link_model.sv ----
`timescale 1ns/10ps
// far end of the link: takes interrupt packets, may stall on command
module sbim_link_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_stall,
  input wire logic i_pkt_valid,
  input wire logic [31:0] i_pkt_bits,
  output logic o_pkt_ready,
  output int o_taken,
  output logic [31:0] o_last_bits
);
  // ----------------------------------------
  // acceptance
  // ----------------------------------------
  // ready follows the stall request one cycle late
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pkt_ready <= 1'b0;
    end else begin
      o_pkt_ready <= !i_stall;
    end
  end

  // count whole packets and keep the last word carried
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_taken <= 0;
      o_last_bits <= 32'h0000_0000;
    end else if (i_pkt_valid && o_pkt_ready) begin
      o_taken <= o_taken + 1;
      o_last_bits <= i_pkt_bits;
    end
  end
endmodule // sbim_link_model

// ---- testbench/serial_bridge_irq_addr_map_test.sv ----
`timescale 1ns/10ps
`define CHECK(nm, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
  end \
end
// bench for the interrupt forwarding and address map block
module serial_bridge_irq_addr_map_test;
  import sbim_pkg::*;
  logic i_clk, i_resetn, i_wr, i_rd, i_stall;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, i_irq_src, o_pkt_bits;
  logic [31:0] i_tx_bus_addr, i_rx_pkt_addr, o_rx_local_addr;
  logic [25:0] o_tx_pkt_addr;
  logic o_module_interrupt_out, o_pkt_valid, i_pkt_ready;
  logic o_rx_hit, o_local_mode, o_int_to_cfg;
  logic [31:0] last_bits;
  int taken, mismatches, comparisons, cycles;

  sbim_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_irq_src(i_irq_src), .o_module_interrupt_out(o_module_interrupt_out),
    .o_pkt_valid(o_pkt_valid), .o_pkt_bits(o_pkt_bits),
    .i_pkt_ready(i_pkt_ready), .i_tx_bus_addr(i_tx_bus_addr),
    .o_tx_pkt_addr(o_tx_pkt_addr), .i_rx_pkt_addr(i_rx_pkt_addr),
    .o_rx_local_addr(o_rx_local_addr), .o_rx_hit(o_rx_hit),
    .o_local_mode(o_local_mode), .o_int_to_cfg(o_int_to_cfg));

  sbim_link_model link (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_stall(i_stall), .i_pkt_valid(o_pkt_valid), .i_pkt_bits(o_pkt_bits),
    .o_pkt_ready(i_pkt_ready), .o_taken(taken), .o_last_bits(last_bits));

  // ----------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------
  // 50 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic close_out;
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, far above the hundred or so cycles used
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHECK(nm, exp, o_rdata)
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset values, reserved bits and an unmapped place
  task automatic t_reset;
    reg_chk("status", SBIM_STAT_OFS, SBIM_RESET_VAL);
    reg_chk("pending", SBIM_PEND_OFS, SBIM_RESET_VAL);
    reg_chk("rebase", SBIM_TXMAP_OFS, SBIM_RESET_VAL);
    reg_chk("size1", SBIM_RXSZ1_OFS, SBIM_RESET_VAL);
    reg_chk("prio_none", SBIM_PRIO_OFS, 32'h8000_0000);
    reg_chk("unmapped", 8'h04, 32'h0000_0000);
    `CHECK("pkt_valid", 1'b0, o_pkt_valid)
    reg_wr(SBIM_PTR_OFS, 32'h0000_0017);
    reg_chk("pointer", SBIM_PTR_OFS, 32'h0000_0014);
  endtask

  // sources latch into status; clear is write-one to set bits only
  task automatic t_status;
    @(posedge i_clk);
    i_irq_src <= 32'h0000_0008;
    @(posedge i_clk);
    i_irq_src <= 32'h0000_0000;
    reg_chk("status_src", SBIM_STAT_OFS, 32'h0000_0008);
    reg_wr(SBIM_STAT_OFS, 32'h0000_0000);
    reg_chk("status_w0", SBIM_STAT_OFS, 32'h0000_0008);
    reg_wr(SBIM_STAT_OFS, 32'h0000_0020);
    reg_chk("status_wclr", SBIM_STAT_OFS, 32'h0000_0008);
    `CHECK("int_remote", 1'b0, o_module_interrupt_out)
    reg_wr(SBIM_STAT_OFS, 32'h0000_0008);
    reg_chk("status_clr", SBIM_STAT_OFS, 32'h0000_0000);
  endtask

  // local handling: pending writes raise the module interrupt
  task automatic t_local;
    reg_wr(SBIM_CTRL_OFS, 32'h0000_0003);
    wait_cyc(1);
    `CHECK("local_mode", 1'b1, o_local_mode)
    `CHECK("int_to_cfg", 1'b1, o_int_to_cfg)
    reg_wr(SBIM_PEND_OFS, 32'h0000_0030);
    wait_cyc(2);
    `CHECK("int_local", 1'b1, o_module_interrupt_out)
    `CHECK("no_packet", 1'b0, o_pkt_valid)
    reg_chk("prio4", SBIM_PRIO_OFS, 32'h0000_0004);
    reg_wr(SBIM_PRIO_OFS, 32'h0000_0004);
    reg_chk("prio5", SBIM_PRIO_OFS, 32'h0000_0005);
    `CHECK("int_still", 1'b1, o_module_interrupt_out)
    reg_wr(SBIM_STAT_OFS, 32'h0000_0020);
    wait_cyc(2);
    `CHECK("int_off", 1'b0, o_module_interrupt_out)
    reg_wr(SBIM_CTRL_OFS, 32'h0000_0000);
  endtask

  // remote handling: packet waits on a stalled link, then clears
  task automatic t_packet;
    int n;
    i_stall <= 1'b1;
    reg_wr(SBIM_PEND_OFS, 32'h0000_0011);
    reg_wr(SBIM_PEND_OFS, 32'h0000_0000);
    reg_chk("pend_hold", SBIM_PEND_OFS, 32'h0000_0011);
    `CHECK("pkt_valid", 1'b1, o_pkt_valid)
    `CHECK("pkt_bits", 32'h0000_0011, o_pkt_bits)
    `CHECK("int_remote", 1'b0, o_module_interrupt_out)
    i_stall <= 1'b0;
    for (n = 0; n < 10 && taken == 0; n++) begin
      wait_cyc(1);
    end
    `CHECK("pkts", 1, taken)
    `CHECK("pkt_word", 32'h0000_0011, last_bits)
    reg_chk("pend_clr", SBIM_PEND_OFS, 32'h0000_0000);
    `CHECK("pkts_once", 1, taken)
  endtask

  // outbound rebase and inbound first and second regions
  task automatic t_map;
    reg_wr(SBIM_TXMAP_OFS, 32'h0000_0103);
    reg_chk("rebase_rd", SBIM_TXMAP_OFS, 32'h0000_0100);
    @(posedge i_clk);
    i_tx_bus_addr <= 32'hFC00_0500;
    wait_cyc(2);
    `CHECK("tx_addr", 26'h000_0400, o_tx_pkt_addr)
    reg_wr(SBIM_TXMAP_OFS, 32'h0000_0000);
    reg_wr(SBIM_RXSZ1_OFS, 32'h0000_1000);
    reg_wr(SBIM_RXOF1_OFS, 32'h8000_0000);
    @(posedge i_clk);
    i_rx_pkt_addr <= 32'h0000_0FFC;
    wait_cyc(2);
    `CHECK("rx_in", 32'h8000_0FFC, o_rx_local_addr)
    `CHECK("rx_hit", 1'b1, o_rx_hit)
    @(posedge i_clk);
    i_rx_pkt_addr <= 32'h0000_1000;
    wait_cyc(2);
    `CHECK("rx_edge", 32'h0000_1000, o_rx_local_addr)
    `CHECK("rx_miss", 1'b0, o_rx_hit)
    // second region, and overlap where the first region must win
    reg_wr(SBIM_RXSZ2_OFS, 32'h0000_2000);
    reg_wr(SBIM_RXOF2_OFS, 32'h4000_0003);
    reg_chk("offset2", SBIM_RXOF2_OFS, 32'h4000_0000);
    @(posedge i_clk);
    i_rx_pkt_addr <= 32'h0000_1004;
    wait_cyc(2);
    `CHECK("rx_two", 32'h4000_1004, o_rx_local_addr)
    `CHECK("rx_two_hit", 1'b1, o_rx_hit)
    @(posedge i_clk);
    i_rx_pkt_addr <= 32'h0000_0800;
    wait_cyc(2);
    `CHECK("rx_first_wins", 32'h8000_0800, o_rx_local_addr)
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    i_resetn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_stall = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_irq_src = 32'h0000_0000;
    i_tx_bus_addr = 32'h0000_0000;
    i_rx_pkt_addr = 32'h0000_0000;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_reset();
    t_status();
    t_local();
    t_packet();
    t_map();
    close_out();
  end
endmodule // serial_bridge_irq_addr_map_test
